// ===== verilog/port_expander_pkg.sv
package port_expander_pkg;

	// Four-level address pin codes, as seen on the addr_sel inputs
	localparam logic [1:0] PIN_GND = 2'h0;
	localparam logic [1:0] PIN_VDD = 2'h1;
	localparam logic [1:0] PIN_SCL = 2'h2;
	localparam logic [1:0] PIN_SDA = 2'h3;

	// Slave address: upper bits fixed, low nibble from the two select pins
	localparam logic [6:0] ADDR_BASE     = 7'h60;
	localparam logic [1:0] ADDR_HIGH_XOR = 2'h2;

	// Eight-bit port layout: bits 7,6,1,0 push-pull, bits 5..2 open-drain
	localparam int         PORT_W    = 8;
	localparam int         OD_N      = 4;
	localparam int         OD_LSB    = 2;
	localparam int         FLAG_LSB  = 2;
	localparam logic [7:0] PORT_RST  = 8'hFF;

	// Serial rate limit and the core clock it is sampled with
	localparam int SCL_MAX_KHZ    = 400;
	localparam int CORE_PERIOD_NS = 8;
	localparam int SCL_PERIOD_NS  = 1000000 / SCL_MAX_KHZ;
	localparam int SCL_PERIOD_CYC = (SCL_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

	// Power-up sequencing in core cycles after reset release
	localparam logic [2:0] INIT_LOAD = 3'h3;
	localparam logic [2:0] INIT_WAIT = 3'h4;

	// Address-select pins travel together
	typedef struct packed {
		logic [1:0] addr_sel_high;
		logic [1:0] addr_sel_low;
	} addr_sel_t;

	// Serial slave states, one-hot
	typedef enum logic [6:0] {
		ST_ADDR      = 7'h01,
		ST_ADDR_ACK  = 7'h02,
		ST_WRITE     = 7'h04,
		ST_WRITE_ACK = 7'h08,
		ST_READ      = 7'h10,
		ST_READ_ACK  = 7'h20,
		ST_IGNORE    = 7'h40
	} link_state_t;

endpackage

// ===== verilog/port_expander_io.sv
`timescale 1ns/1ps
module port_expander_io (
	input  wire logic                          core_clk,
	input  wire logic                          sys_rst,
	input  wire logic                          scl_clk,
	input  wire logic                          sda_in,
	output wire logic                          sda_out,
	output wire logic                          sda_oe,
	input  wire logic                          clear_n,
	input  wire port_expander_pkg::addr_sel_t  addr_sel,
	input  wire logic [3:0]                    od_port_in,
	output wire logic [3:0]                    od_port_out,
	output wire logic [3:0]                    od_port_oe,
	output wire logic [3:0]                    pullup_en,
	output wire logic [3:0]                    pp_out,
	output wire logic                          alert_n_out,
	output wire logic                          alert_n_oe
);
	import port_expander_pkg::*;

	// Core-domain synchroniser stages and edge-detect copies
	logic                  scl_m_r, scl_s_r;
	logic                  sda_m_r, sda_s_r, sda_d_r;
	logic                  clr_m_r, clr_s_r;
	logic [OD_N-1:0]       od_m_r, od_s_r, od_d_r;
	addr_sel_t             sel_m_r, sel_s_r;
	logic                  wr_m_r, wr_s_r, wr_d_r;
	logic                  acc_m_r, acc_s_r, acc_d_r;
	logic [2:0]            init_cnt_r;
	logic [PORT_W-1:0]     port_out_r;
	logic [OD_N-1:0]       flags_r;
	logic                  alert_r;
	logic [3:0]            pullup_r;
	logic                  link_rst_r;
	logic                  arm_r;

	// Link-domain state
	link_state_t           state_r;
	logic [2:0]            bit_cnt_r;
	logic [6:0]            shift_r;
	logic [PORT_W-1:0]     tx_r;
	logic                  read_r;
	logic                  byte_sel_r;
	logic                  sda_oe_r;
	logic [PORT_W-1:0]     wr_data_r;
	logic                  wr_tgl_r;
	logic                  acc_tgl_r;
	addr_sel_t             lsel_m_r, lsel_s_r;
	logic [PORT_W-1:0]     pin_m_r, pin_s_r;
	logic [OD_N-1:0]       flg_m_r, flg_s_r;
	logic [OD_N-1:0]       flg_hold_r;

	logic                  init_done;
	logic                  init_load;
	logic                  start_evt;
	logic                  stop_evt;
	logic                  wr_evt;
	logic                  acc_evt;
	logic [OD_N-1:0]       od_chg;
	logic                  sel_high_on;
	logic                  sel_low_on;
	logic [PORT_W-1:0]     dflt_byte;
	logic [6:0]            my_addr;
	logic [PORT_W-1:0]     pin_byte;

	// Two-stage synchronisers; the bus is sampled far faster than SCL_PERIOD_CYC
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_m_r <= 1'h1;
			scl_s_r <= 1'h1;
			sda_m_r <= 1'h1;
			sda_s_r <= 1'h1;
			sda_d_r <= 1'h1;
			clr_m_r <= 1'h1;
			clr_s_r <= 1'h1;
			od_m_r  <= 4'h0;
			od_s_r  <= 4'h0;
			od_d_r  <= 4'h0;
			sel_m_r <= {PIN_VDD, PIN_VDD};
			sel_s_r <= {PIN_VDD, PIN_VDD};
			wr_m_r  <= 1'h0;
			wr_s_r  <= 1'h0;
			wr_d_r  <= 1'h0;
			acc_m_r <= 1'h0;
			acc_s_r <= 1'h0;
			acc_d_r <= 1'h0;
		end else begin
			scl_m_r <= scl_clk;
			scl_s_r <= scl_m_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
			clr_m_r <= clear_n;
			clr_s_r <= clr_m_r;
			od_m_r  <= od_port_in;
			od_s_r  <= od_m_r;
			od_d_r  <= od_s_r;
			sel_m_r <= addr_sel;
			sel_s_r <= sel_m_r;
			wr_m_r  <= wr_tgl_r;
			wr_s_r  <= wr_m_r;
			wr_d_r  <= wr_s_r;
			acc_m_r <= acc_tgl_r;
			acc_s_r <= acc_m_r;
			acc_d_r <= acc_s_r;
		end
	end

	// Event decode in the core domain
	assign start_evt   = scl_s_r & sda_d_r & ~sda_s_r;
	assign stop_evt    = scl_s_r & ~sda_d_r & sda_s_r;
	assign wr_evt      = wr_s_r ^ wr_d_r;
	assign acc_evt     = acc_s_r ^ acc_d_r;
	assign init_done   = (init_cnt_r == INIT_WAIT);
	assign init_load   = (init_cnt_r == INIT_LOAD);
	assign od_chg      = init_done ? (od_s_r ^ od_d_r) : 4'h0;
	assign sel_high_on = (sel_s_r.addr_sel_high != PIN_GND);
	assign sel_low_on  = (sel_s_r.addr_sel_low != PIN_GND);
	assign dflt_byte   = {{4{sel_high_on}}, {4{sel_low_on}}};

	// Power-up sequencing waits for the address pins to settle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_cnt_r <= 3'h0;
		end else if (!init_done) begin
			init_cnt_r <= init_cnt_r + 3'h1;
		end
	end

	// Port latches: strapped defaults once, then serial writes
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			port_out_r <= PORT_RST;
		end else if (init_load) begin
			port_out_r <= dflt_byte;
		end else if (init_done && wr_evt) begin
			port_out_r <= wr_data_r;
		end
	end

	// Pullups follow the select pins, a pair per pin
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pullup_r <= 4'hF;
		end else begin
			pullup_r <= {{2{sel_high_on}}, {2{sel_low_on}}};
		end
	end

	// Transition flags: a change in the clearing cycle still sets
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_r <= 4'h0;
		end else begin
			flags_r <= (acc_evt ? 4'h0 : flags_r) | od_chg;
		end
	end

	// Latched alert, only for ports floating as inputs; clear input ignored
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			alert_r <= 1'h0;
		end else begin
			alert_r <= (alert_r & ~acc_evt) | (|(od_chg & port_out_r[OD_LSB +: OD_N]));
		end
	end

	// Link reset: held while idle or in a start, dropped when SCL goes low
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			link_rst_r <= 1'h1;
			arm_r      <= 1'h0;
		end else if (!clr_s_r) begin
			link_rst_r <= 1'h1;
			arm_r      <= 1'h0;
		end else if (start_evt) begin
			link_rst_r <= 1'h1;
			arm_r      <= 1'h1;
		end else if (stop_evt) begin
			link_rst_r <= 1'h1;
			arm_r      <= 1'h0;
		end else if (arm_r && !scl_s_r) begin
			link_rst_r <= 1'h0;
			arm_r      <= 1'h0;
		end
	end

	// Pin outputs
	assign pp_out      = {port_out_r[7:6], port_out_r[1:0]};
	assign od_port_out = 4'h0;
	assign od_port_oe  = ~port_out_r[OD_LSB +: OD_N];
	assign pullup_en   = pullup_r;
	assign alert_n_out = 1'h0;
	assign alert_n_oe  = alert_r;
	assign sda_out     = 1'h0;
	assign sda_oe      = sda_oe_r;

	// Link-side view of pins, outputs and own address
	assign pin_byte = {port_out_r[7:6], od_port_in, port_out_r[1:0]};
	assign my_addr  = {ADDR_BASE[6:4], lsel_s_r.addr_sel_high ^ ADDR_HIGH_XOR,
		lsel_s_r.addr_sel_low};

	// Link-domain synchronisers, refreshed on every bus clock
	always_ff @(posedge scl_clk or posedge link_rst_r) begin
		if (link_rst_r) begin
			lsel_m_r <= {PIN_VDD, PIN_VDD};
			lsel_s_r <= {PIN_VDD, PIN_VDD};
			pin_m_r  <= 8'h00;
			pin_s_r  <= 8'h00;
			flg_m_r  <= 4'h0;
			flg_s_r  <= 4'h0;
		end else begin
			lsel_m_r <= addr_sel;
			lsel_s_r <= lsel_m_r;
			pin_m_r  <= pin_byte;
			pin_s_r  <= pin_m_r;
			flg_m_r  <= flags_r;
			flg_s_r  <= flg_m_r;
		end
	end

	// Serial slave on the rising bus clock
	always_ff @(posedge scl_clk or posedge link_rst_r) begin
		if (link_rst_r) begin
			state_r    <= ST_ADDR;
			bit_cnt_r  <= 3'h0;
			shift_r    <= 7'h00;
			tx_r       <= 8'h00;
			read_r     <= 1'h0;
			byte_sel_r <= 1'h0;
			flg_hold_r <= 4'h0;
		end else begin
			unique case (state_r)
				ST_ADDR: begin
					shift_r   <= {shift_r[5:0], sda_in};
					bit_cnt_r <= bit_cnt_r + 3'h1;
					if (bit_cnt_r == 3'h7) begin
						read_r  <= sda_in;
						state_r <= (shift_r == my_addr) ? ST_ADDR_ACK : ST_IGNORE;
					end
				end
				ST_ADDR_ACK: begin
					bit_cnt_r  <= 3'h0;
					byte_sel_r <= 1'h0;
					tx_r       <= pin_s_r;
					flg_hold_r <= flg_s_r; // Snapshot before this access clears the flags
					state_r    <= read_r ? ST_READ : ST_WRITE;
				end
				ST_WRITE: begin
					shift_r   <= {shift_r[5:0], sda_in};
					bit_cnt_r <= bit_cnt_r + 3'h1;
					if (bit_cnt_r == 3'h7) begin
						state_r <= ST_WRITE_ACK;
					end
				end
				ST_WRITE_ACK: begin
					bit_cnt_r <= 3'h0;
					state_r   <= ST_WRITE;
				end
				ST_READ: begin
					bit_cnt_r <= bit_cnt_r + 3'h1;
					if (bit_cnt_r == 3'h7) begin
						state_r <= ST_READ_ACK;
					end
				end
				ST_READ_ACK: begin
					bit_cnt_r <= 3'h0;
					if (sda_in) begin
						state_r <= ST_IGNORE;
					end else begin
						state_r    <= ST_READ;
						byte_sel_r <= ~byte_sel_r;
						tx_r       <= byte_sel_r ? pin_s_r : 8'({4'h0, flg_hold_r} << FLAG_LSB);
					end
				end
				ST_IGNORE: begin
					state_r <= ST_IGNORE;
				end
				default: begin
					state_r <= ST_IGNORE;
				end
			endcase
		end
	end

	// Write data and access events leave the link domain as toggles
	always_ff @(posedge scl_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_data_r <= 8'h00;
			wr_tgl_r  <= 1'h0;
			acc_tgl_r <= 1'h0;
		end else begin
			if (!link_rst_r && state_r == ST_ADDR_ACK) begin
				acc_tgl_r <= ~acc_tgl_r;
			end
			if (!link_rst_r && state_r == ST_WRITE && bit_cnt_r == 3'h7) begin
				wr_data_r <= {shift_r, sda_in};
				wr_tgl_r  <= ~wr_tgl_r;
			end
		end
	end

	// Data line driven on the falling bus clock
	always_ff @(negedge scl_clk or posedge link_rst_r) begin
		if (link_rst_r) begin
			sda_oe_r <= 1'h0;
		end else begin
			sda_oe_r <= (state_r == ST_ADDR_ACK) | (state_r == ST_WRITE_ACK) |
				((state_r == ST_READ) & ~tx_r[3'h7 - bit_cnt_r]);
		end
	end

	// Checks in the core domain
	sequence s_clear_seen;
		!clr_s_r;
	endsequence
	sequence s_link_held;
		link_rst_r && !arm_r;
	endsequence
	property p_clear_abort;
		@(posedge core_clk) disable iff (sys_rst) s_clear_seen |=> s_link_held;
	endproperty
	a_clear_abort: assert property (p_clear_abort) else $error("clear did not hold link");
	property p_flag_set;
		@(posedge core_clk) disable iff (sys_rst)
			(od_chg != 4'h0) |=> ((flags_r & $past(od_chg)) == $past(od_chg));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set on change");
	property p_flag_clear;
		@(posedge core_clk) disable iff (sys_rst)
			(acc_evt && od_chg == 4'h0) |=> (flags_r == 4'h0);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flags kept after access");
	property p_alert_set;
		@(posedge core_clk) disable iff (sys_rst)
			((od_chg & port_out_r[OD_LSB +: OD_N]) != 4'h0) |=> alert_n_oe [*2];
	endproperty
	a_alert_set: assert property (p_alert_set) else $error("alert not latched");
	property p_alert_clear;
		@(posedge core_clk) disable iff (sys_rst)
			(acc_evt && (od_chg & port_out_r[OD_LSB +: OD_N]) == 4'h0) |=> !alert_n_oe;
	endproperty
	a_alert_clear: assert property (p_alert_clear) else $error("alert kept after access");
	property p_clear_keeps_alert;
		@(posedge core_clk) disable iff (sys_rst)
			(!clr_s_r && alert_r && !acc_evt) |=> alert_r;
	endproperty
	a_clear_keeps_alert: assert property (p_clear_keeps_alert) else $error("clear lost alert");
	property p_od_release;
		@(posedge core_clk) disable iff (sys_rst)
			(init_done && wr_evt) |=> (od_port_oe == ~$past(wr_data_r[OD_LSB +: OD_N]));
	endproperty
	a_od_release: assert property (p_od_release) else $error("open-drain enable wrong");
	property p_init_default;
		@(posedge core_clk) disable iff (sys_rst)
			init_load |=> (pp_out == {{2{$past(sel_high_on)}}, {2{$past(sel_low_on)}}});
	endproperty
	a_init_default: assert property (p_init_default) else $error("bad power-up level");

	// Checks in the link domain
	property p_addr_ack;
		@(posedge scl_clk) disable iff (link_rst_r) (state_r == ST_ADDR_ACK) |-> sda_oe_r;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
	property p_ignore;
		@(posedge scl_clk) disable iff (link_rst_r) (state_r == ST_IGNORE) |-> !sda_oe_r;
	endproperty
	a_ignore: assert property (p_ignore) else $error("drove bus for other slave");
	sequence s_write_tail;
		(state_r == ST_WRITE_ACK) ##1 (state_r == ST_WRITE);
	endsequence
	property p_write_byte;
		@(posedge scl_clk) disable iff (link_rst_r)
			(state_r == ST_WRITE && bit_cnt_r == 3'h7) |=> s_write_tail;
	endproperty
	a_write_byte: assert property (p_write_byte) else $error("write byte not acknowledged");

endmodule // port_expander_io

// ===== tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model #(
	parameter int HALF_NS = 80
) (
	output logic      scl_clk,
	output logic      sda_drv,
	input  wire logic sda_lvl
);
	// Idle bus: clock stands high, data left to its pull-up
	initial begin
		scl_clk = 1'b1;
		sda_drv = 1'b0;
	end
	// Data falls while clock high; long low lets the core see it
	task automatic start();
		sda_drv = 1'b0;
		#(HALF_NS*2);
		sda_drv = 1'b1;
		#(HALF_NS*2);
		scl_clk = 1'b0;
		#1300;
	endtask
	// Data changes only while clock is low; sampled mid-high
	task automatic put_bit(input logic b, output logic s);
		#(HALF_NS/2);
		sda_drv = ~b;
		#(HALF_NS/2);
		scl_clk = 1'b1;
		#(HALF_NS/2);
		s = sda_lvl;
		#(HALF_NS/2);
		scl_clk = 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge bit
	task automatic put_byte(input logic [7:0] tx, input logic ack_rel,
		output logic [7:0] rx, output logic ack_lvl);
		for (int i = 7; i >= 0; i--) begin
			put_bit(tx[i], rx[i]);
		end
		put_bit(ack_rel, ack_lvl);
	endtask
	// Data rises while clock high, then bus free time
	task automatic stop();
		#(HALF_NS/2);
		sda_drv = 1'b1;
		#(HALF_NS/2);
		scl_clk = 1'b1;
		#(HALF_NS);
		sda_drv = 1'b0;
		#(HALF_NS*4);
	endtask
endmodule // i2c_master_model

// ===== tb/i2c_port_expander_io_test.sv
`timescale 1ns/1ps
module i2c_port_expander_io_test;
	import port_expander_pkg::*;
	localparam addr_sel_t HOME  = {PIN_SDA, PIN_VDD};
	localparam int        LIMIT = 60000;
	logic       core_clk, sys_rst, clear_n, scl_clk, sda_drv;
	logic       sda_out, sda_oe, alert_n_out, alert_n_oe, ack;
	addr_sel_t  addr_sel;
	logic [3:0] ext_low, od_port_out, od_port_oe, pullup_en, pp_out, e;
	logic [7:0] b0, b1;
	wire logic  sda_lvl;
	wire logic [3:0] od_lvl;
	int         n_fail, tests_run, cyc;
	// Wire levels: any party pulling low wins, pull-ups otherwise
	assign sda_lvl = (sda_drv | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
	assign od_lvl  = ~(ext_low | (od_port_oe & ~od_port_out));
	always #4 core_clk = ~core_clk;
	i2c_master_model mst (.scl_clk(scl_clk), .sda_drv(sda_drv), .sda_lvl(sda_lvl));
	port_expander_io uut (.core_clk(core_clk), .sys_rst(sys_rst), .scl_clk(scl_clk),
		.sda_in(sda_lvl), .sda_out(sda_out), .sda_oe(sda_oe), .clear_n(clear_n),
		.addr_sel(addr_sel), .od_port_in(od_lvl), .od_port_out(od_port_out),
		.od_port_oe(od_port_oe), .pullup_en(pullup_en), .pp_out(pp_out),
		.alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe));
	// Hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			final_report();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	function automatic logic [6:0] addr_of(input addr_sel_t a);
		return ADDR_BASE | {3'h0, a.addr_sel_high ^ ADDR_HIGH_XOR, a.addr_sel_low};
	endfunction
	// Expected pullup and default pattern {P5,P4,P3,P2} for a selection
	function automatic logic [3:0] pairs(input addr_sel_t a);
		return {{2{|a.addr_sel_high}}, {2{|a.addr_sel_low}}};
	endfunction
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		mst.start();
		mst.put_byte({a, 1'b0}, 1'b1, b0, ack);
		if (ack === 1'b0) mst.put_byte(d, 1'b1, b0, b1[0]);
		mst.stop();
		tick(10);
	endtask
	task automatic rd();
		mst.start();
		mst.put_byte({addr_of(HOME), 1'b1}, 1'b1, b0, ack);
		mst.put_byte(8'hFF, 1'b0, b0, e[0]);
		mst.put_byte(8'hFF, 1'b1, b1, e[0]);
		mst.stop();
		tick(10);
	endtask
	task automatic do_reset(input addr_sel_t a);
		tick(1);
		sys_rst = 1'b1;
		addr_sel = a;
		tick(16);
		sys_rst = 1'b0;
		tick(12);
	endtask
	task automatic t_power_up();
		for (int i = 0; i < 4; i++) begin
			do_reset({i[1] ? PIN_VDD : PIN_GND, i[0] ? PIN_SCL : PIN_GND});
			e = pairs(addr_sel);
			check(pullup_en, e);
			check(pp_out, e);
			check(od_port_oe, 4'(~e));
			check(alert_n_oe, 1'b0);
		end
		do_reset(HOME);
		$display("test power_up done");
	endtask
	task automatic t_address();
		for (int i = 0; i < 16; i++) begin
			addr_sel = i[3:0];
			wr(addr_of(addr_sel) ^ 7'h01, 8'hFF);
			check(ack, 1'b1);
			wr(addr_of(addr_sel), 8'hFF);
			check(ack, 1'b0);
			check(pullup_en, pairs(addr_sel));
		end
		addr_sel = HOME;
		$display("test address done");
	endtask
	task automatic t_write_read();
		wr(addr_of(HOME), 8'h6D);
		check(pp_out, 4'h5);
		check(od_port_oe, 4'h4);
		check(alert_n_oe, 1'b0);
		ext_low = 4'h1;
		tick(8);
		check(alert_n_oe, 1'b1);
		rd();
		check(b0, 8'h69);
		check(b1, 8'h14);
		check(alert_n_oe, 1'b0);
		rd();
		check(b1, 8'h00);
		ext_low = 4'h0;
		wr(addr_of(HOME), 8'hFF);
		$display("test write_read done");
	endtask
	task automatic t_momentary();
		rd();
		ext_low = 4'h8;
		tick(3);
		ext_low = 4'h0;
		tick(8);
		check(alert_n_oe, 1'b1);
		wr(addr_of(HOME), 8'hFF);
		check(alert_n_oe, 1'b0);
		rd();
		check(b1, 8'h00);
		$display("test momentary done");
	endtask
	task automatic t_clear();
		ext_low = 4'h8;
		tick(8);
		mst.start();
		for (int i = 7; i >= 0; i--) mst.put_bit(i > 0 ? addr_of(HOME) >> (i - 1) : 1'b0, ack);
		#40;
		check(sda_oe, 1'b1);
		tick(1);
		clear_n = 1'b0;
		tick(6);
		check(sda_oe, 1'b0);
		check(alert_n_oe, 1'b1);
		clear_n = 1'b1;
		tick(4);
		mst.stop();
		tick(130);
		ext_low = 4'h0;
		wr(addr_of(HOME), 8'hFF);
		check(ack, 1'b0);
		check(alert_n_oe, 1'b0);
		$display("test clear done");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		clear_n = 1'b1;
		addr_sel = HOME;
		ext_low = 4'h0;
		n_fail = 0;
		tests_run = 0;
		cyc = 0;
		t_power_up();
		t_address();
		t_write_read();
		t_momentary();
		t_clear();
		final_report();
	end
endmodule // i2c_port_expander_io_test
